// [shared/fbdp_pkg.sv]
// Package with register map, field layout and timing constants of the data port
package fbdp_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CHANNELS = 4;

  // Register byte addresses
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_INVERT = 12'h004;
  localparam logic [11:0] OFF_FILTER_EN = 12'h008;
  localparam logic [11:0] OFF_FILTER_TIME = 12'h00C;
  localparam logic [11:0] OFF_COMMAND = 12'h010;
  localparam logic [11:0] OFF_OUT_DATA = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;

  // Config register bit positions
  localparam int unsigned CFG_JOINT_INV = 0;
  localparam int unsigned CFG_P1_FILTER = 1;
  localparam int unsigned CFG_MUX_DATA = 2;
  localparam int unsigned CFG_MUX_PARAM = 3;

  // Command register bit positions
  localparam int unsigned CMD_EXCHANGE = 0;
  localparam int unsigned CMD_WRITE_PARAM = 1;
  localparam int unsigned CMD_DELETE_ADDR = 2;

  // Safe output value and bus-cycle filter time code
  localparam logic [3:0] OUT_SAFE = 4'hF;
  localparam logic [2:0] FILTER_CYCLE_CODE = 3'h7;

  // Times in nanoseconds and derived cycle counts
  localparam int unsigned SETUP_NS = 500;
  localparam int unsigned STROBE_NS = 5500;
  localparam int unsigned ACCEPT_MIN_NS = 11000;
  localparam int unsigned ACCEPT_MAX_NS = 13500;
  localparam int unsigned SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAMPLE_CYC = ((ACCEPT_MIN_NS + ACCEPT_MAX_NS) / 2) * CLK_MHZ / 1000;
  // Filter timebase tick: 8 us, 128 us is 16 ticks (tolerance taken on the short side)
  localparam int unsigned TICK_NS = 8000;
  localparam int unsigned TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam int unsigned BASE_TICKS = 16;
  localparam int unsigned BLOCK_TICKS = 30;

  typedef struct packed {
    logic joint_inv;
    logic p1_filter;
    logic mux_data;
    logic mux_param;
  } fbdp_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_WAIT = 5'b10000
  } fbdp_state_t;

endpackage : fbdp_pkg

// [logic/fbdp_port.sv]
// Slave data port: output latch, strobe, input sampling, inversion and filters
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module fbdp_port
  import fbdp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] input_pins,
  input wire logic parameter_pin_one,
  output logic [3:0] out_pins_o,
  output logic [3:0] out_pins_oe_n,
  output logic strobe,
  output logic param_pin_one_mux_off,
  output logic [3:0] response_data,
  output logic response_valid
);

  // Elaboration checks: the counters below are sized for these ranges only
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  // The sequence counter is 16 bits wide and must reach the sampling point
  if (SAMPLE_CYC > 65535) begin : g_bad_sample
    $error("SAMPLE_CYC does not fit the sequence counter");
  end
  // Sampling must come after strobe and hold, or the wait state runs on until the sequence counter wraps
  if (SAMPLE_CYC <= 2 * SETUP_CYC + STROBE_CYC) begin : g_bad_order
    $error("SAMPLE_CYC too short for strobe and hold");
  end
  // Sampling point must lie inside the acceptance window
  if (SAMPLE_CYC * 1000 < ACCEPT_MIN_NS * CLK_MHZ ||
      SAMPLE_CYC * 1000 > ACCEPT_MAX_NS * CLK_MHZ) begin : g_bad_window
    $error("SAMPLE_CYC outside the acceptance window");
  end
  // Longest filter time, code 6, must fit the 11-bit tick counters
  if ((BASE_TICKS << 6) > 2047) begin : g_bad_filter
    $error("BASE_TICKS too large for the filter counters");
  end
  // Blocking window counter is 6 bits wide and must not be zero
  if (BLOCK_TICKS < 1 || BLOCK_TICKS > 63) begin : g_bad_block
    $error("BLOCK_TICKS out of range");
  end
  // Register fields and pins are four channels wide
  if (CHANNELS != 4) begin : g_bad_width
    $error("CHANNELS must be 4");
  end

  // Configuration image and port registers
  fbdp_cfg_t cfg;
  logic [3:0] input_invert_select;
  logic [3:0] input_filter_enable;
  logic [2:0] input_filter_time;
  logic [3:0] out_reg;
  logic inhibit;
  logic out_release;
  // Strobe sequencer; one pending flag queues a strobe that arrives mid-sequence
  fbdp_state_t state;
  logic [15:0] seq_cnt;
  logic pending_strobe;
  // Timebase shared by all filters and the blocking window
  logic [15:0] tick_div;
  logic tick;
  // Filters, sample history and response
  logic [10:0] ticks_done [CHANNELS];
  logic [3:0] filt_out;
  logic [3:0] filt_view;
  logic [3:0] sampled;
  logic [3:0] prev_sample;
  logic [5:0] block_cnt;
  logic sample_evt;
  logic cyc_take;
  logic have_prev;
  logic [3:0] inv_in;
  logic [10:0] filt_ticks;
  logic use_raw;
  // Bus address phase and decoded commands
  logic ap_valid;
  logic ap_write;
  logic [11:0] ap_addr;
  logic wr_cmd;
  logic exch;
  logic write_parameter_request;
  logic deladdr;

  // Address phase capture for AHB-Lite; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
    end else if (hready) begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr[11:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_cmd = ap_valid & ap_write & (ap_addr == OFF_COMMAND);
  assign exch = wr_cmd & hwdata[CMD_EXCHANGE] & ~inhibit;
  assign write_parameter_request = wr_cmd & hwdata[CMD_WRITE_PARAM];
  assign deladdr = wr_cmd & hwdata[CMD_DELETE_ADDR];

  // Configuration registers, nonvolatile image written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '0;
      input_invert_select <= 4'h0;
      input_filter_enable <= 4'h0;
      input_filter_time <= 3'h0;
    end else if (ap_valid & ap_write) begin
      case (ap_addr)
        OFF_CONFIG: cfg <= fbdp_cfg_t'({hwdata[CFG_JOINT_INV], hwdata[CFG_P1_FILTER],
                                        hwdata[CFG_MUX_DATA], hwdata[CFG_MUX_PARAM]});
        OFF_INVERT: input_invert_select <= hwdata[3:0];
        OFF_FILTER_EN: input_filter_enable <= hwdata[3:0];
        OFF_FILTER_TIME: input_filter_time <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        OFF_CONFIG: hrdata <= {28'h000_0000, cfg.mux_param, cfg.mux_data,
                               cfg.p1_filter, cfg.joint_inv};
        OFF_INVERT: hrdata <= {28'h000_0000, input_invert_select};
        OFF_FILTER_EN: hrdata <= {28'h000_0000, input_filter_enable};
        OFF_FILTER_TIME: hrdata <= {29'h0000_0000, input_filter_time};
        OFF_OUT_DATA: hrdata <= {28'h000_0000, out_reg};
        OFF_STATUS: hrdata <= {26'h000_0000, out_release, inhibit, response_data};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Inhibit flag: delete-address wins over a simultaneous write-parameter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inhibit <= 1'b1;
    end else if (deladdr) begin
      inhibit <= 1'b1;
    end else if (write_parameter_request) begin
      inhibit <= 1'b0;
    end
  end

  // Output holding register; safe value on reset and delete-address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_reg <= OUT_SAFE;
      out_release <= 1'b1;
    end else if (deladdr) begin
      out_reg <= OUT_SAFE;
      out_release <= 1'b1;
    end else if (exch) begin
      out_reg <= hwdata[7:4];
      out_release <= 1'b0;
    end
  end

  // Strobe sequencer; reset leaves a strobe pending so one is issued after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      seq_cnt <= 16'h0000;
      pending_strobe <= 1'b1;
    end else begin
      if (exch || deladdr) begin
        pending_strobe <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (pending_strobe || exch || deladdr) begin
            pending_strobe <= 1'b0;
            state <= ST_SETUP;
            seq_cnt <= 16'h0000;
          end
        end
        ST_SETUP: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == 16'(SETUP_CYC - 1)) begin
            state <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == 16'(SETUP_CYC + STROBE_CYC - 1)) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == 16'(2 * SETUP_CYC + STROBE_CYC - 1)) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == 16'(SAMPLE_CYC - 1)) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sampling event at acceptance time of any strobe sequence that ends while not inhibited
  assign sample_evt = (state == ST_WAIT) && (seq_cnt == 16'(SAMPLE_CYC - 1)) && !inhibit;

  // Open-drain drive: low output bit pulls pin; mux mode releases during strobe and hold
  always_comb begin
    strobe = (state == ST_STROBE);
    for (int i = 0; i < CHANNELS; i++) begin
      out_pins_o[i] = 1'b0;
      out_pins_oe_n[i] = out_release | out_reg[i];
      if (cfg.mux_data && (state == ST_STROBE || state == ST_HOLD)) begin
        out_pins_oe_n[i] = 1'b1;
      end
    end
  end

  assign param_pin_one_mux_off = cfg.mux_param & cfg.p1_filter;

  // Free-running timebase tick from the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_div <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_div == 16'(TICK_CYCLES - 1));
      tick_div <= (tick_div == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_div + 16'h0001;
    end
  end

  // Inversion ahead of the filters
  assign inv_in = cfg.joint_inv ? ~input_pins : (input_pins ^ input_invert_select);
  assign filt_ticks = 11'(BASE_TICKS) << input_filter_time;

  // Bus-cycle mode accepts a sample only outside the blocking window
  assign cyc_take = (input_filter_time == FILTER_CYCLE_CODE) && sample_evt &&
                    (block_cnt == 6'h00) && have_prev;

  // Filter value seen by the response; a second equal sample is reported at once,
  // since taking the registered output would lag one exchange behind
  always_comb begin
    filt_view = filt_out;
    for (int i = 0; i < CHANNELS; i++) begin
      if (cyc_take && inv_in[i] == prev_sample[i]) begin
        filt_view[i] = inv_in[i];
      end
    end
  end

  // Per-channel debounce filters in time mode
  for (genvar g = 0; g < CHANNELS; g++) begin : g_filter
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ticks_done[g] <= 11'h000;
        filt_out[g] <= 1'b0;
      end else if (input_filter_time == FILTER_CYCLE_CODE) begin
        ticks_done[g] <= 11'h000;
        if (cyc_take && inv_in[g] == prev_sample[g]) begin
          filt_out[g] <= inv_in[g];
        end
      end else if (inv_in[g] == filt_out[g]) begin
        ticks_done[g] <= 11'h000;
      end else if (tick) begin
        if (ticks_done[g] + 11'h001 >= filt_ticks) begin
          filt_out[g] <= inv_in[g];
          ticks_done[g] <= 11'h000;
        end else begin
          ticks_done[g] <= ticks_done[g] + 11'h001;
        end
      end
    end
  end

  // Bus-cycle mode sample history and blocking window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_sample <= 4'h0;
      have_prev <= 1'b0;
      block_cnt <= 6'h00;
    end else begin
      if (block_cnt != 6'h00 && tick) begin
        block_cnt <= block_cnt - 6'h01;
      end
      if (sample_evt && block_cnt == 6'h00) begin
        prev_sample <= inv_in;
        have_prev <= 1'b1;
        block_cnt <= 6'(BLOCK_TICKS);
      end
    end
  end

  // Response selection: raw when pin one high under pin control
  assign use_raw = cfg.p1_filter & parameter_pin_one;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sampled <= 4'h0;
      response_valid <= 1'b0;
    end else begin
      response_valid <= sample_evt;
      if (sample_evt) begin
        for (int i = 0; i < CHANNELS; i++) begin
          sampled[i] <= (input_filter_enable[i] && !use_raw) ? filt_view[i] : inv_in[i];
        end
      end
    end
  end

  assign response_data = sampled;

endmodule : fbdp_port

// [verification/fbdp_port_asserts.sv]
// Concurrent checks on the data port outputs
`timescale 1ns/10ps
module fbdp_port_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] out_pins_o,
  input wire logic [3:0] out_pins_oe_n,
  input wire logic strobe,
  input wire logic [3:0] response_data,
  input wire logic response_valid
);
  logic [9:0] hi_cnt;
  logic [10:0] since;
  logic strobe_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Length of the running strobe pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hi_cnt <= 10'h000;
    else
      hi_cnt <= strobe ? hi_cnt + 10'h001 : 10'h000;
  end
  // Cycles since strobe rose; starts saturated so a response without strobe fails
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since <= 11'h7FF;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
      since <= (strobe && !strobe_q) ? 11'h001 : since + {10'h000, since != 11'h7FF};
    end
  end
  chk_open_drain: assert property (out_pins_o == 4'h0)
    else $error("output line driven high");
  chk_strobe_len: assert property ($fell(strobe) |-> hi_cnt inside {[10'h271:10'h2EE]})
    else $error("strobe width out of range");
  chk_strobe_gap: assert property ($fell(strobe) |-> !strobe [*8])
    else $error("strobe pulses merged");
  chk_sample_time: assert property (response_valid |-> since inside {[11'h514:11'h690]})
    else $error("input sample outside acceptance time");
  chk_valid_pulse: assert property (response_valid |=> !response_valid)
    else $error("response valid longer than one cycle");
  chk_resp_update: assert property ($changed(response_data) |-> ##[0:1] response_valid)
    else $error("response changed without sample");
  chk_reset_safe: assert property ($rose(hresetn) |-> out_pins_oe_n == 4'hF)
    else $error("outputs not released after reset");
  chk_reset_strobe: assert property ($rose(hresetn) |-> ##[12:76] strobe)
    else $error("no strobe after reset");
endmodule : fbdp_port_asserts

bind fbdp_port fbdp_port_asserts u_chk (.hclk, .hresetn, .out_pins_o, .out_pins_oe_n,
  .strobe, .response_data, .response_valid);

// [verification/fbdp_ext_model.sv]
// External circuitry: input sources and pull-ups on the open-drain outputs
`timescale 1ns/10ps
module fbdp_ext_model (
  input wire logic hclk,
  input wire logic strobe,
  input wire logic [3:0] out_pins_oe_n,
  input wire logic [3:0] next_in,
  output logic [3:0] input_pins,
  output logic [3:0] out_level
);
  logic strobe_q = 1'b0;
  // Line is pulled up unless the device sinks it
  assign out_level = out_pins_oe_n;
  // New levels only at strobe rise, so they stand through the acceptance window
  initial begin
    input_pins = 4'h0;
    forever begin
      @(posedge hclk);
      strobe_q <= strobe;
      if (strobe && !strobe_q)
        input_pins <= next_in;
    end
  end
endmodule : fbdp_ext_model

// [verification/fbdp_port_tb.sv]
// Self-checking bench of the slave data port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module fbdp_port_tb;
  import fbdp_pkg::*;
  logic hclk, hreadyout, hresp, strobe, mux_off, response_valid;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ppo = 1'b0, stq = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rdat;
  logic [1:0] htrans = 2'b00;
  logic [3:0] input_pins, out_o, oe_n, response_data, out_level, next_in = 4'hA;
  logic [3:0] oe_seen = 4'h0;
  logic [3:0] t_cfg [3] = '{4'h1, 4'h0, 4'h0};
  logic [3:0] t_inv [3] = '{4'h3, 4'h3, 4'h0};
  logic [3:0] t_exp [3] = '{4'h9, 4'h5, 4'h6};
  int error_cnt = 0;
  int n_tests = 0;
  int n_strobe = 0;
  // Short timebase tick keeps filter times within the run
  fbdp_port #(.TICK_CYCLES(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .input_pins(input_pins), .parameter_pin_one(ppo), .out_pins_o(out_o),
    .out_pins_oe_n(oe_n), .strobe(strobe), .param_pin_one_mux_off(mux_off),
    .response_data(response_data), .response_valid(response_valid));
  fbdp_ext_model ext (.hclk(hclk), .strobe(strobe), .out_pins_oe_n(oe_n),
    .next_in(next_in), .input_pins(input_pins), .out_level(out_level));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Strobe pulses seen on the pin
  always @(posedge hclk) begin
    stq <= strobe;
    if (strobe === 1'b1 && stq === 1'b0) begin
      n_strobe++;
      oe_seen <= oe_n;
    end
  end
  // One single AHB-Lite transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("register", e, rdat)
  endtask : rc
  // Exchange request; an inhibited one simply runs out the wait
  task automatic ex(input logic [3:0] d);
    bus(1'b1, OFF_COMMAND, {24'h00_0000, d, 4'h1});
    for (int i = 0; i < 3000 && response_valid !== 1'b1; i++)
      @(posedge hclk);
  endtask : ex
  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (1600) @(posedge hclk);
    rc(OFF_STATUS, 32'h0000_0030);
    rc(OFF_OUT_DATA, {28'h000_0000, OUT_SAFE});
    rc(12'h0FC, 32'h0000_0000);
    ex(4'h3);
    `CHK("strobes", 1, n_strobe)
    rc(OFF_OUT_DATA, 32'h0000_000F);
    bus(1'b1, OFF_COMMAND, 32'h0000_0002);
    rc(OFF_STATUS, 32'h0000_0020);
    next_in <= 4'h6;
    ex(4'h5);
    `CHK("response", 4'h6, response_data)
    `CHK("out level", 4'h5, out_level)
    `CHK("drive at strobe", 4'h5, oe_seen)
    rc(OFF_STATUS, 32'h0000_0006);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFF_CONFIG, {28'h000_0000, t_cfg[i]});
      bus(1'b1, OFF_INVERT, {28'h000_0000, t_inv[i]});
      ex(4'h5);
      `CHK("inverted", t_exp[i], response_data)
    end
    bus(1'b1, OFF_FILTER_TIME, 32'h0000_0006);
    bus(1'b1, OFF_FILTER_EN, 32'h0000_000F);
    repeat (5000) @(posedge hclk);
    next_in <= 4'h9;
    ex(4'h5);
    `CHK("filtered", 4'h6, response_data)
    bus(1'b1, OFF_FILTER_EN, 32'h0000_000E);
    ex(4'h5);
    `CHK("per channel", 4'h7, response_data)
    ppo <= 1'b1;
    bus(1'b1, OFF_CONFIG, 32'h0000_000A);
    @(posedge hclk);
    `CHK("mux off", 1'b1, mux_off)
    ex(4'h5);
    `CHK("raw", 4'h9, response_data)
    bus(1'b1, OFF_CONFIG, 32'h0000_0000);
    bus(1'b1, OFF_FILTER_EN, 32'h0000_000F);
    bus(1'b1, OFF_FILTER_TIME, {29'h0000_0000, FILTER_CYCLE_CODE});
    next_in <= 4'h3;
    ex(4'h5);
    `CHK("cycle first", 1'b1, response_data !== 4'h3)
    ex(4'h5);
    `CHK("cycle second", 4'h3, response_data)
    bus(1'b1, OFF_CONFIG, 32'h0000_0004);
    ex(4'h5);
    `CHK("mux release", 4'hF, oe_seen)
    `CHK("mux off", 1'b0, mux_off)
    bus(1'b1, OFF_COMMAND, 32'h0000_0006);
    repeat (1600) @(posedge hclk);
    `CHK("strobes", 12, n_strobe)
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    `CHK("flags", 2'b11, rdat[5:4])
    `CHK("out level", 4'hF, out_level)
    ex(4'h0);
    rc(OFF_OUT_DATA, 32'h0000_000F);
    test_done();
  end
endmodule : fbdp_port_tb
